// ### dsc_defines.vh
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

// bit positions of the low register half
`define DSC_EXEC_BIT      13
`define DSC_UDIS_BIT      12
`define DSC_IMASK_BIT     11
`define DSC_FACK_BIT      10
`define DSC_RSVD_BIT      9
`define DSC_SUND_BIT      8
`define DSC_SIMP_BIT      7
`define DSC_SPRE_BIT      6
`define DSC_MOE_HI        5
`define DSC_MOE_LO        2
`define DSC_RESTART_BIT   1
`define DSC_HALTED_BIT    0
`define DSC_CLR_STICKY    2

// entry method encodings
`define DSC_MOE_HALTREQ   4'h0
`define DSC_MOE_BREAK     4'h1
`define DSC_MOE_EXTHALT   4'h4
`define DSC_MOE_BKPTINS   4'h3
`define DSC_MOE_WATCH     4'ha

// coprocessor selector fields
`define DSC_CP_OPC1       3'h0
`define DSC_CP_CRN        4'h0
`define DSC_CP_CRM        4'h1
`define DSC_CP_OPC2       3'h0

// reset values
`define DSC_CTRL_RESET    4'h0
`define DSC_MOE_RESET     4'h0
`define DSC_STATE_RESET   2'h2

`endif

// ### dsc_state_track.v
`timescale 1ns/10ps
`default_nettype none
`include "dsc_defines.vh"

// live halted / restarted status, reset only by processor power-on reset
module dsc_state_track (
	input  wire       clk,
	input  wire       system_power_on_reset_n,
	input  wire       core_in_debug,
	input  wire       core_leaving_debug,
	output wire [1:0] state_bits
);
	reg [1:0] state_q;
	reg [1:0] state_d;

	// restarted low while exiting, halted high in debug state
	always @* begin
		state_d = {~core_leaving_debug, core_in_debug};
	end

	// debug-logic reset deliberately absent here
	always @(posedge clk) begin
		if (!system_power_on_reset_n) begin
			state_q <= `DSC_STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign state_bits = state_q;
endmodule
`default_nettype wire

// ### dsc_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "dsc_defines.vh"

// Overview of operation
// - enable bit plus transfer write fetches instruction
// - user access disable raises undefined exception
// - interrupt mask bit blocks irq and fiq
// - force ack bit drives ack high
// - bit nine reads zero, ignores writes
// - sticky undefined set in debug, run-control clear
// - sticky imprecise abort set, run-control clear
// - sticky precise abort set, run-control clear
// - entry method field records debug cause
// - restarted bit low while leaving debug
// - halted bit high while in debug
// - state bits survive debug reset only
// - coprocessor move with c0 c1 selects register
module dsc_ctrl (
	input  wire        clk,
	input  wire        resetn,
	input  wire        system_power_on_reset_n,
	input  wire        core_in_debug,
	input  wire        core_leaving_debug,
	input  wire        cp_valid,
	input  wire        cp_write,
	input  wire        cp_user_mode,
	input  wire [2:0]  cp_opc1,
	input  wire [3:0]  cp_crn,
	input  wire [3:0]  cp_crm,
	input  wire [2:0]  cp_opc2,
	input  wire [31:0] cp_wdata,
	output reg  [31:0] cp_rdata,
	output wire        cp_undef,
	input  wire        ext_wr,
	input  wire [13:0] ext_wdata,
	input  wire        run_ctrl_wr,
	input  wire [31:0] run_ctrl_wdata,
	input  wire        instr_transfer_wr_ok,
	output wire        instr_fetch,
	input  wire        irq_in,
	input  wire        fiq_in,
	output wire        irq_out,
	output wire        fiq_out,
	output wire        debug_ack_out,
	input  wire        undef_event,
	input  wire        imprecise_abort_event,
	input  wire        precise_abort_event,
	input  wire        entry_valid,
	input  wire [3:0]  entry_cause,
	output wire [13:0] status_low
);
	reg  [3:0]  ctrl_q;
	reg  [3:0]  ctrl_d;
	reg  [2:0]  sticky_q;
	reg  [2:0]  sticky_d;
	reg  [3:0]  moe_q;
	reg  [3:0]  moe_d;
	reg         ack_q;
	reg  [13:0] wr_val;
	reg         wr_en;
	wire [1:0]  state_bits;
	wire        sel_reg;
	wire        sticky_clr;
	wire [2:0]  sticky_set;

	// halted and restarted bits on the processor reset
	dsc_state_track u_state (
		.clk                     (clk),
		.system_power_on_reset_n (system_power_on_reset_n),
		.core_in_debug           (core_in_debug),
		.core_leaving_debug      (core_leaving_debug),
		.state_bits              (state_bits)
	);

	// coprocessor selector decode
	assign sel_reg = cp_valid && (cp_opc1 == `DSC_CP_OPC1) && (cp_crn == `DSC_CP_CRN) &&
		(cp_crm == `DSC_CP_CRM) && (cp_opc2 == `DSC_CP_OPC2);

	// user access refused when disabled
	assign cp_undef = sel_reg && cp_user_mode && ctrl_q[`DSC_UDIS_BIT - 10];

	// write source: coprocessor first, then debugger
	always @* begin
		wr_en  = 1'b0;
		wr_val = 14'h0000;
		if (sel_reg && cp_write && !cp_undef) begin
			wr_en  = 1'b1;
			wr_val = cp_wdata[13:0];
		end else if (ext_wr) begin
			wr_en  = 1'b1;
			wr_val = ext_wdata;
		end
	end

	// writable control bits 13..10
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_en) begin
			ctrl_d = wr_val[13:10];
		end
	end

	// sticky flags: set wins over run-control clear
	assign sticky_clr = run_ctrl_wr && run_ctrl_wdata[`DSC_CLR_STICKY];
	assign sticky_set = {undef_event, imprecise_abort_event, precise_abort_event} &
		{3{core_in_debug}};
	always @* begin
		sticky_d = sticky_q;
		if (sticky_clr) begin
			sticky_d = 3'h0;
		end
		sticky_d = sticky_d | sticky_set;
	end

	// entry method captured on each debug event with a listed cause
	always @* begin
		moe_d = moe_q;
		if (entry_valid) begin
			case (entry_cause)
				`DSC_MOE_HALTREQ,
				`DSC_MOE_BREAK,
				`DSC_MOE_EXTHALT,
				`DSC_MOE_BKPTINS,
				`DSC_MOE_WATCH: begin
					moe_d = entry_cause;
				end
				default: begin
					moe_d = moe_q;
				end
			endcase
		end
	end

	// debug-logic registers
	always @(posedge clk) begin
		if (!resetn) begin
			ctrl_q   <= `DSC_CTRL_RESET;
			sticky_q <= 3'h0;
			moe_q    <= `DSC_MOE_RESET;
			ack_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			sticky_q <= sticky_d;
			moe_q    <= moe_d;
			ack_q    <= ctrl_d[`DSC_FACK_BIT - 10] | core_in_debug;
		end
	end

	// register image, bit nine reads zero
	assign status_low = {ctrl_q, 1'b0, sticky_q, moe_q, state_bits};

	// read data registered
	always @(posedge clk) begin
		if (!resetn) begin
			cp_rdata <= 32'h0000_0000;
		end else if (sel_reg && !cp_write && !cp_undef) begin
			cp_rdata <= {18'h0_0000, status_low};
		end
	end

	// execute injected instruction on accepted transfer write
	assign instr_fetch = ctrl_q[`DSC_EXEC_BIT - 10] & instr_transfer_wr_ok;

	// interrupt masking
	assign irq_out = irq_in & ~ctrl_q[`DSC_IMASK_BIT - 10];
	assign fiq_out = fiq_in & ~ctrl_q[`DSC_IMASK_BIT - 10];

	assign debug_ack_out = ack_q;
endmodule
`default_nettype wire

// ### dsc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_core_model (
	input  wire logic clk, go,
	output var  logic dbg = 1'b0, lv = 1'b0
);
	// halt on request, exit through a one-cycle leaving phase
	always @(negedge clk) begin
		lv <= dbg && !go && !lv;
		dbg <= go || (dbg && !lv);
	end
endmodule
`default_nettype wire

// ### dsc_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_checker (
	input wire logic        clk, resetn, system_power_on_reset_n, core_in_debug,
	input wire logic        core_leaving_debug, cp_valid, cp_user_mode, cp_undef, undef_event,
	input wire logic        instr_transfer_wr_ok, instr_fetch, irq_out, fiq_out, debug_ack_out,
	input wire logic [2:0]  cp_opc1, cp_opc2,
	input wire logic [3:0]  cp_crn, cp_crm,
	input wire logic [13:0] status_low
);
	// register select decode
	wire sel = cp_valid && cp_opc1 == 3'h0 && cp_crn == 4'h0 && cp_crm == 4'h1 && cp_opc2 == 3'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn || !system_power_on_reset_n);
	property p_fetch; instr_fetch == (status_low[13] && instr_transfer_wr_ok); endproperty
	a_fetch: assert property (p_fetch) else $error("bad fetch");
	property p_undef; sel && cp_user_mode && status_low[12] |-> cp_undef; endproperty
	a_undef: assert property (p_undef) else $error("no undef");
	property p_mask; status_low[11] |-> !irq_out && !fiq_out; endproperty
	a_mask: assert property (p_mask) else $error("irq leak");
	property p_ack; status_low[10] |-> debug_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("ack low");
	property p_debug_ack_out; core_in_debug |=> debug_ack_out; endproperty
	a_debug_ack_out: assert property (p_debug_ack_out) else $error("ack low in debug");
	property p_rsvd; !status_low[9]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("bit9 set");
	property p_sund; undef_event && core_in_debug |=> status_low[8]; endproperty
	a_sund: assert property (p_sund) else $error("sticky lost");
	property p_rst; core_leaving_debug |=> !status_low[1]; endproperty
	a_rst: assert property (p_rst) else $error("restart bit");
	property p_halt; core_in_debug |=> status_low[0]; endproperty
	a_halt: assert property (p_halt) else $error("halt bit");
endmodule
bind dsc_ctrl dsc_checker u_dsc_checker (.*);
`default_nettype wire

// ### dsc_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_ctrl_tb;
	logic clk = 0, rn = 0, pn = 0, go = 0, v = 0, w, u, ew, rw, ok, iq, fq, ue, ia, pa, ev, sel;
	logic dbg, lv, ud, fe, io, fo, ak;
	logic [3:0] crm, ec;
	logic [31:0] wd, rd;
	logic [13:0] sl;
	int n_fail = 0, samples_checked = 0, cyc = 0, ctl = 0, stk = 0, entry_method_field = 0, st = 2, ack = 0;
	int xr = 0, rv = 0;
	dsc_ctrl u_dsc_ctrl (.clk, .resetn(rn), .system_power_on_reset_n(pn), .core_in_debug(dbg),
		.core_leaving_debug(lv), .cp_valid(v), .cp_write(w), .cp_user_mode(u), .cp_opc1(3'h0),
		.cp_crn(4'h0), .cp_crm(crm), .cp_opc2(3'h0), .cp_wdata(wd), .cp_rdata(rd), .cp_undef(ud),
		.ext_wr(ew), .ext_wdata(wd[13:0]), .run_ctrl_wr(rw), .run_ctrl_wdata(wd),
		.instr_transfer_wr_ok(ok), .instr_fetch(fe), .irq_in(iq), .fiq_in(fq), .irq_out(io),
		.fiq_out(fo), .debug_ack_out(ak), .undef_event(ue), .imprecise_abort_event(ia),
		.precise_abort_event(pa), .entry_valid(ev), .entry_cause(ec), .status_low(sl));
	dsc_core_model u_dsc_core_model (.clk, .go, .dbg, .lv);
	always #25 clk = ~clk;
	task check(input logic [50:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// reference model, updated on each sampling edge
	always @(posedge clk) begin
		if (++cyc > 4000) begin
			n_fail++;
			test_done;
		end
		sel = rn && v && crm == 4'h1 && !(u && ctl[12]);
		if (sel && !w) begin
			xr = ctl | stk | entry_method_field | st;
			rv = 1;
		end
		if (sel && w) ctl = wd & 32'h0000_3c00;
		else if (ew) ctl = wd & 32'h0000_3c00;
		ack = ctl[10] | dbg;
		if (rw && wd[2]) stk = 0;
		stk = stk | (dbg ? int'({ue, ia, pa}) << 6 : 0);
		if (ev && ec inside {4'h0, 4'h1, 4'h3, 4'h4, 4'ha}) entry_method_field = int'(ec) << 2;
		st = {!lv, dbg};
		if (!rn) {ctl, stk, entry_method_field, ack, xr} = 0;
		if (!pn) st = 2;
	end
	// compare, then drive random stimulus off the falling edge
	initial begin
		{w, u, ew, rw, ok, iq, fq, ue, ia, pa, ev, crm, ec, wd} = 0;
		void'($urandom(32'h6404_b407));
		repeat (2) @(negedge clk);
		{rn, pn} = 2'b11;
		repeat (3000) begin
			@(negedge clk);
			check({rv ? rd : 32'h0, sl, ak, io, fo, fe, ud}, {xr, 14'(ctl | stk | entry_method_field | st), ack[0],
				iq & !ctl[11], fq & !ctl[11], ok & ctl[13], v & crm == 4'h1 & u & ctl[12]});
			{v, w, u, ew, rw, ok, iq, fq, ue, ia, pa, ev} = $urandom;
			crm = $urandom % 4 ? 4'h1 : 4'h0;
			wd = $urandom;
			wd[13] = wd[13] & dbg;
			ec = $urandom;
			if ($urandom % 30 == 0) go = !go;
			rn = $urandom % 50 != 0;
			pn = $urandom % 90 != 0;
		end
		test_done;
	end
endmodule
`default_nettype wire
